// ==== rtl/synth_regs_pkg.sv ====
package synth_regs_pkg;
	localparam logic [3:0] tx_power_level_offset = 4'hb;
	localparam logic [3:0] synth_loop_control_offset = 4'hc;
	localparam logic [3:0] lock_detect_control_offset = 4'hd;
	localparam logic [3:0] irq_status_offset = 4'he;
	localparam logic [3:0] irq_mask_offset = 4'hf;
	localparam logic [3:0] high_array_level_reset = 4'h0;
	localparam logic [3:0] low_array_level_reset = 4'hf;
	localparam logic [3:0] reference_divisor_reset = 4'h2;
	localparam logic [3:0] pin_select_reset = 4'h0;
	localparam int filter_sel_bit = 7;
	localparam int reference_divisor_lsb = 3;
	localparam int alarm_disable_bit = 2;
	localparam int alarm_high_bit = 1;
	localparam int alarm_low_bit = 0;
	localparam int pin_select_lsb = 4;
	localparam int lock_accuracy_bit = 3;
	localparam int lock_length_bit = 2;
	localparam int momentary_bit = 1;
	localparam int steady_bit = 0;
	localparam logic [7:0] lock_set_fine = 8'h7f;
	localparam logic [7:0] lock_clear_fine = 8'h6f;
	localparam logic [7:0] lock_set_coarse = 8'h1f;
	localparam logic [7:0] lock_clear_coarse = 8'h0f;
	localparam logic [3:0] sel_charge_pump = 4'h0;
	localparam logic [3:0] sel_steady_lock = 4'h1;
	localparam logic [3:0] sel_momentary_lock = 4'h2;
	localparam logic [3:0] sel_alarm_high = 4'h3;
	localparam logic [3:0] sel_alarm_low = 4'h4;
	localparam logic [3:0] sel_cal_done = 4'h5;
	localparam logic [3:0] sel_if_out = 4'h6;
	localparam logic [3:0] sel_ref_div = 4'h7;
	localparam logic [3:0] sel_tx_amp = 4'h8;
	localparam logic [3:0] sel_violation = 4'h9;
	localparam logic [3:0] sel_rx_amp = 4'ha;
	localparam logic [3:0] sel_averager = 4'hd;
	localparam logic [3:0] sel_feedback_div = 4'he;
	localparam logic [3:0] sel_phase_comp = 4'hf;
	localparam int irq_steady_bit = 0;
	localparam int irq_loss_bit = 1;
	localparam int irq_alarm_high_bit = 2;
	localparam int irq_alarm_low_bit = 3;
endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser per bit
module pin_sync #(
	parameter int width = 1
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [width-1:0] i_async,
	output logic [width-1:0] o_sync
);
	logic [width-1:0] first_reg;
	genvar g;
	generate
		for (g = 0; g < width; g++) begin : bit_sync
			always_ff @(posedge i_clock) begin
				if (i_reset) begin
					first_reg[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					first_reg[g] <= i_async[g];
					o_sync[g] <= first_reg[g];
				end
			end
		end
	endgenerate
endmodule

// ==== rtl/pll_lock_config_regs.sv ====
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
module pll_lock_config_regs (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_loop_break,
	input wire logic i_phase_comp,
	input wire logic i_in_window,
	input wire logic i_near_supply,
	input wire logic i_near_ground,
	input wire logic i_charge_pump,
	input wire logic i_cal_done,
	input wire logic i_if_out,
	input wire logic i_ref_div_out,
	input wire logic i_transmit_amp_enable,
	input wire logic i_violation,
	input wire logic i_receive_amp_enable,
	input wire logic i_averager_locked,
	input wire logic i_feedback_div_out,
	output logic [3:0] o_high_array_level,
	output logic [3:0] o_low_array_level,
	output logic o_outside_loop_filter_sel,
	output logic [3:0] o_reference_divisor,
	output logic o_alarm_enable,
	output logic o_lock_window_long,
	output logic o_sampled_phase_comp,
	output logic o_charge_pump_pin,
	output logic o_irq
);
	localparam int n_sync = 14;
	logic [n_sync-1:0] raw_in;
	logic [n_sync-1:0] sync_in;
	logic [3:0] high_level_reg;
	logic [3:0] low_level_reg;
	logic filter_sel_reg;
	logic [3:0] reference_divisor_reg;
	logic alarm_disable_reg;
	logic [3:0] pin_select_reg;
	logic accuracy_reg;
	logic length_reg;
	logic sampled_reg;
	logic [7:0] lock_count_reg;
	logic steady_reg;
	logic momentary_reg;
	logic alarm_high_reg;
	logic alarm_low_reg;
	logic [3:0] irq_status_reg;
	logic [3:0] irq_mask_reg;
	logic [3:0] irq_event;
	logic [31:0] readdata_reg;
	logic answered_reg;
	logic steady_prev_reg;
	logic alarm_high_prev_reg;
	logic alarm_low_prev_reg;
	logic write_hit;
	logic read_hit;
	logic lane0;
	logic pin_next;
	logic [7:0] set_thresh;
	logic [7:0] clear_thresh;
	logic s_phase;
	logic s_window;
	logic s_supply;
	logic s_ground;
	logic s_break;
	logic s_charge_pump;
	logic s_cal_done;
	logic s_if_out;
	logic s_ref_div;
	logic s_tx_amp;
	logic s_violation;
	logic s_rx_amp;
	logic s_averager;
	logic s_feedback;

	assign raw_in = {i_phase_comp, i_in_window, i_near_supply,
		i_near_ground, i_charge_pump, i_cal_done, i_if_out,
		i_ref_div_out, i_transmit_amp_enable, i_violation,
		i_receive_amp_enable, i_averager_locked, i_feedback_div_out,
		i_loop_break};

	// analogue and pin-side flags arrive asynchronously
	pin_sync #(
		.width(n_sync)
	) u_sync (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_async(raw_in),
		.o_sync(sync_in)
	);

	assign s_phase = sync_in[13];
	assign s_window = sync_in[12];
	assign s_supply = sync_in[11];
	assign s_ground = sync_in[10];
	assign s_charge_pump = sync_in[9];
	assign s_cal_done = sync_in[8];
	assign s_if_out = sync_in[7];
	assign s_ref_div = sync_in[6];
	assign s_tx_amp = sync_in[5];
	assign s_violation = sync_in[4];
	assign s_rx_amp = sync_in[3];
	assign s_averager = sync_in[2];
	assign s_feedback = sync_in[1];
	assign s_break = sync_in[0];

	// one wait cycle per access, answer from a register
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~answered_reg;
	// writes land on the edge that ends the wait, as the master sees it
	assign write_hit = i_avs_write & answered_reg;
	// reads fetch early so the data already stands when the wait ends
	assign read_hit = i_avs_read & ~answered_reg;
	assign lane0 = i_avs_byteenable[0];

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			answered_reg <= 1'b0;
		end else begin
			answered_reg <= (i_avs_read | i_avs_write) & ~answered_reg;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			high_level_reg <= synth_regs_pkg::high_array_level_reset;
			low_level_reg <= synth_regs_pkg::low_array_level_reset;
		end else if (write_hit && lane0 &&
			i_avs_address == synth_regs_pkg::tx_power_level_offset) begin
			high_level_reg <= i_avs_writedata[7:4];
			low_level_reg <= i_avs_writedata[3:0];
		end
	end

	// status bits 1:0 are not stored from writes
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			filter_sel_reg <= 1'b0;
			reference_divisor_reg <= synth_regs_pkg::reference_divisor_reset;
			alarm_disable_reg <= 1'b0;
		end else if (write_hit && lane0 &&
			i_avs_address == synth_regs_pkg::synth_loop_control_offset) begin
			filter_sel_reg <=
				i_avs_writedata[synth_regs_pkg::filter_sel_bit];
			// forbidden codes are stored as written; software must avoid
			reference_divisor_reg <= i_avs_writedata[synth_regs_pkg::reference_divisor_lsb +: 4];
			alarm_disable_reg <=
				i_avs_writedata[synth_regs_pkg::alarm_disable_bit];
		end
	end

	// a written 1-to-0 on filter select under loop break
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			sampled_reg <= 1'b0;
		end else if (write_hit && lane0 && s_break && filter_sel_reg &&
			!i_avs_writedata[synth_regs_pkg::filter_sel_bit] &&
			i_avs_address == synth_regs_pkg::synth_loop_control_offset) begin
			sampled_reg <= s_phase;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			pin_select_reg <= synth_regs_pkg::pin_select_reset;
			accuracy_reg <= 1'b0;
			length_reg <= 1'b0;
		end else if (write_hit && lane0 &&
			i_avs_address == synth_regs_pkg::lock_detect_control_offset) begin
			pin_select_reg <= i_avs_writedata[synth_regs_pkg::pin_select_lsb +: 4];
			accuracy_reg <= i_avs_writedata[synth_regs_pkg::lock_accuracy_bit];
			length_reg <= i_avs_writedata[synth_regs_pkg::lock_length_bit];
		end
	end

	// alarm flags follow the comparators only while enabled
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			alarm_high_reg <= 1'b0;
			alarm_low_reg <= 1'b0;
		end else begin
			alarm_high_reg <= s_supply & ~alarm_disable_reg;
			alarm_low_reg <= s_ground & ~alarm_disable_reg;
		end
	end

	always_comb begin
		if (accuracy_reg) begin
			set_thresh = synth_regs_pkg::lock_set_coarse;
			clear_thresh = synth_regs_pkg::lock_clear_coarse;
		end else begin
			set_thresh = synth_regs_pkg::lock_set_fine;
			clear_thresh = synth_regs_pkg::lock_clear_fine;
		end
	end

	// count runs of in-window comparisons; a miss restarts the run
	// saturates so a long lock never wraps back below the thresholds
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lock_count_reg <= 8'h00;
		end else if (!s_window) begin
			lock_count_reg <= 8'h00;
		end else if (lock_count_reg != 8'hff) begin
			lock_count_reg <= lock_count_reg + 8'h01;
		end
	end

	// steady flag holds with hysteresis; momentary follows the count
	// limitation: the clear is judged only in a cycle with a miss
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			steady_reg <= 1'b0;
			momentary_reg <= 1'b0;
		end else begin
			momentary_reg <= (lock_count_reg >= set_thresh);
			if (lock_count_reg >= set_thresh) begin
				steady_reg <= 1'b1;
			end else if (lock_count_reg < clear_thresh && !s_window) begin
				steady_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (pin_select_reg)
			synth_regs_pkg::sel_charge_pump: pin_next = s_charge_pump;
			synth_regs_pkg::sel_steady_lock: pin_next = steady_reg;
			synth_regs_pkg::sel_momentary_lock:
				pin_next = momentary_reg;
			synth_regs_pkg::sel_alarm_high: pin_next = alarm_high_reg;
			synth_regs_pkg::sel_alarm_low: pin_next = alarm_low_reg;
			synth_regs_pkg::sel_cal_done: pin_next = s_cal_done;
			synth_regs_pkg::sel_if_out: pin_next = s_if_out;
			synth_regs_pkg::sel_ref_div: pin_next = s_ref_div;
			synth_regs_pkg::sel_tx_amp: pin_next = s_tx_amp;
			synth_regs_pkg::sel_violation: pin_next = s_violation;
			synth_regs_pkg::sel_rx_amp: pin_next = s_rx_amp;
			synth_regs_pkg::sel_averager: pin_next = s_averager;
			synth_regs_pkg::sel_feedback_div: pin_next = s_feedback;
			synth_regs_pkg::sel_phase_comp: pin_next = s_phase;
			default: pin_next = 1'b0; // undefined codes drive low
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_charge_pump_pin <= 1'b0;
		end else begin
			o_charge_pump_pin <= pin_next;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			steady_prev_reg <= 1'b0;
			alarm_high_prev_reg <= 1'b0;
			alarm_low_prev_reg <= 1'b0;
		end else begin
			steady_prev_reg <= steady_reg;
			alarm_high_prev_reg <= alarm_high_reg;
			alarm_low_prev_reg <= alarm_low_reg;
		end
	end

	assign irq_event = {alarm_low_reg & ~alarm_low_prev_reg,
		alarm_high_reg & ~alarm_high_prev_reg,
		steady_prev_reg & ~steady_reg,
		steady_reg & ~steady_prev_reg};

	// read of status clears it, but a same-cycle event wins
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_status_reg <= 4'h0;
		end else if (read_hit &&
			i_avs_address == synth_regs_pkg::irq_status_offset) begin
			irq_status_reg <= irq_event;
		end else begin
			irq_status_reg <= irq_status_reg | irq_event;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_mask_reg <= 4'h0;
		end else if (write_hit && lane0 &&
			i_avs_address == synth_regs_pkg::irq_mask_offset) begin
			irq_mask_reg <= i_avs_writedata[3:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			readdata_reg <= 32'h00000000;
		end else if (read_hit) begin
			// unmapped indexes read as zero
			unique case (i_avs_address)
				synth_regs_pkg::tx_power_level_offset:
					readdata_reg <= {24'h000000, high_level_reg, low_level_reg};
				synth_regs_pkg::synth_loop_control_offset:
					readdata_reg <= {24'h000000, filter_sel_reg, reference_divisor_reg,
						alarm_disable_reg, alarm_high_reg,
						alarm_low_reg};
				synth_regs_pkg::lock_detect_control_offset:
					readdata_reg <= {24'h000000, pin_select_reg, accuracy_reg,
						length_reg, momentary_reg, steady_reg};
				synth_regs_pkg::irq_status_offset:
					readdata_reg <= {28'h0000000, irq_status_reg};
				synth_regs_pkg::irq_mask_offset:
					readdata_reg <= {28'h0000000, irq_mask_reg};
				default: readdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign o_avs_readdata = readdata_reg;
	assign o_irq = |(irq_status_reg & irq_mask_reg);
	assign o_high_array_level = high_level_reg;
	assign o_low_array_level = low_level_reg;
	assign o_outside_loop_filter_sel = filter_sel_reg;
	assign o_reference_divisor = reference_divisor_reg;
	assign o_alarm_enable = ~alarm_disable_reg;
	assign o_lock_window_long = length_reg;
	assign o_sampled_phase_comp = sampled_reg;
endmodule

// ==== bench/regs_monitor.sv ====
`timescale 1ns/10ps
module regs_monitor (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [3:0] o_high_array_level,
	input wire logic [3:0] o_low_array_level,
	input wire logic o_outside_loop_filter_sel,
	input wire logic [3:0] o_reference_divisor,
	input wire logic o_alarm_enable,
	input wire logic o_lock_window_long,
	input wire logic o_sampled_phase_comp,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	wire logic req = i_avs_read | i_avs_write;
	wire logic [14:0] cfg = {o_high_array_level, o_low_array_level,
		o_outside_loop_filter_sel, o_reference_divisor, o_alarm_enable,
		o_lock_window_long};
	property p_one_wait;
		$rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait count");
	property p_idle;
		!req |-> !o_avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("idle wait");
	property p_rst_pow;
		$fell(i_reset) |-> o_high_array_level == 4'h0
			&& o_low_array_level == 4'hf;
	endproperty
	a_rst_pow: assert property (p_rst_pow)
		else $error("power reset value");
	property p_rst_pll;
		$fell(i_reset) |-> !o_outside_loop_filter_sel && o_alarm_enable
			&& o_reference_divisor == 4'h2 && !o_lock_window_long;
	endproperty
	a_rst_pll: assert property (p_rst_pll)
		else $error("loop reset value");
	// config only moves on a taken write
	property p_cfg_hold;
		!(i_avs_write && !o_avs_waitrequest) |=> $stable(cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config moved");
	property p_smp_hold;
		!(i_avs_write && !o_avs_waitrequest) |=>
			$stable(o_sampled_phase_comp);
	endproperty
	a_smp_hold: assert property (p_smp_hold)
		else $error("sample moved");
	property p_rd_hold;
		!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
	property p_rd_top;
		o_avs_readdata[31:8] == 24'h0;
	endproperty
	a_rd_top: assert property (p_rd_top) else $error("upper readdata");
	c_wr: cover property (i_avs_write && !o_avs_waitrequest);
	c_rd: cover property (i_avs_read && !o_avs_waitrequest);
	c_irq: cover property ($rose(o_irq));
endmodule
bind pll_lock_config_regs regs_monitor regs_monitor_i (.i_clock, .i_reset,
	.i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.o_high_array_level, .o_low_array_level, .o_outside_loop_filter_sel,
	.o_reference_divisor, .o_alarm_enable, .o_lock_window_long,
	.o_sampled_phase_comp, .o_irq);

// ==== bench/host_model.sv ====
`timescale 1ns/10ps
module host_model (
	input wire logic i_clock,
	input wire logic i_waitrequest,
	input wire logic [31:0] i_readdata,
	output logic [3:0] o_address = 4'h0,
	output logic o_read = 1'b0,
	output logic o_write = 1'b0,
	output logic [31:0] o_writedata = 32'h0,
	output logic [3:0] o_byteenable = 4'h0
);
	task automatic wr(input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		logic [7:0] v;
		v = (a == 4'hd) ? (d & 8'hfb) : d;
		if (a == 4'hc && d[6:4] == 3'h0) v[6:3] = 4'h2;
		@(posedge i_clock);
		o_address <= a;
		o_writedata <= {24'h0, v};
		o_byteenable <= be;
		o_write <= 1'b1;
		do @(posedge i_clock); while (i_waitrequest !== 1'b0);
		o_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clock);
		o_address <= a;
		o_read <= 1'b1;
		do @(posedge i_clock); while (i_waitrequest !== 1'b0);
		d = i_readdata;
		o_read <= 1'b0;
	endtask
endmodule

// ==== bench/pll_lock_config_regs_tb.sv ====
`timescale 1ns/10ps
module pll_lock_config_regs_tb;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic brk = 1'b0, win = 1'b0, hi = 1'b0, lo = 1'b0;
	logic [15:0] src = 16'h0;
	logic [3:0] adr, be, hl, ll, rdv;
	logic [31:0] wd, rdat, r;
	logic rd_s, wr_s, wt, fsel, aen, wlong, smp, pin, irq;
	int miscompares = 0;
	int n_tests = 0;
	always #10 i_clock = ~i_clock;
	host_model host_model_i (.i_clock(i_clock), .i_waitrequest(wt),
		.i_readdata(rdat), .o_address(adr), .o_read(rd_s),
		.o_write(wr_s), .o_writedata(wd), .o_byteenable(be));
	pll_lock_config_regs pll_lock_config_regs_i (
		.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(adr),
		.i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wt), .i_loop_break(brk),
		.i_phase_comp(src[15]), .i_in_window(win), .i_near_supply(hi),
		.i_near_ground(lo), .i_charge_pump(src[0]), .i_cal_done(src[5]),
		.i_if_out(src[6]), .i_ref_div_out(src[7]),
		.i_transmit_amp_enable(src[8]), .i_violation(src[9]),
		.i_receive_amp_enable(src[10]), .i_averager_locked(src[13]),
		.i_feedback_div_out(src[14]), .o_high_array_level(hl),
		.o_low_array_level(ll), .o_outside_loop_filter_sel(fsel),
		.o_reference_divisor(rdv), .o_alarm_enable(aen),
		.o_lock_window_long(wlong), .o_sampled_phase_comp(smp),
		.o_charge_pump_pin(pin), .o_irq(irq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("miscompares %0d of %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	// one-cycle gap survives the input synchroniser
	task automatic miss();
		@(posedge i_clock);
		win <= 1'b0;
		@(posedge i_clock);
		win <= 1'b1;
	endtask
	task automatic t_reset();
		host_model_i.rd(4'hb, r);
		chk(r, 32'h0f);
		host_model_i.rd(4'hc, r);
		chk(r, 32'h10);
		host_model_i.rd(4'hd, r);
		chk(r, 32'h00);
		chk(wlong, 1'b0);
		chk({pin, irq}, 2'b00);
		host_model_i.rd(4'h3, r);
		chk(r, 32'h00);
	endtask
	task automatic t_power();
		host_model_i.wr(4'hb, 8'ha5, 4'h1);
		host_model_i.wr(4'hb, 8'h33, 4'h0);
		host_model_i.wr(4'h3, 8'h33, 4'h1);
		chk({hl, ll}, 8'ha5);
		host_model_i.rd(4'hb, r);
		chk(r, 32'ha5);
	endtask
	task automatic t_synth();
		host_model_i.wr(4'hc, 8'hff, 4'h1);
		cyc(1);
		chk({fsel, rdv, aen}, {1'b1, 4'hf, 1'b0});
		host_model_i.rd(4'hc, r);
		chk(r, 32'hfc);
	endtask
	task automatic t_break();
		@(posedge i_clock);
		brk <= 1'b1;
		src[15] <= 1'b1;
		cyc(4);
		chk(smp, 1'b0);
		host_model_i.wr(4'hc, 8'h10, 4'h1);
		cyc(1);
		chk(smp, 1'b1);
		brk <= 1'b0;
	endtask
	task automatic t_alarm();
		@(posedge i_clock);
		hi <= 1'b1;
		lo <= 1'b1;
		cyc(5);
		host_model_i.rd(4'hc, r);
		chk(r, 32'h13);
		chk(irq, 1'b0);
		host_model_i.wr(4'hd, 8'h30, 4'h1);
		cyc(2);
		chk(pin, 1'b1);
		host_model_i.wr(4'hd, 8'h40, 4'h1);
		cyc(2);
		chk(pin, 1'b1);
		host_model_i.wr(4'hf, 8'h04, 4'h1);
		cyc(1);
		chk(irq, 1'b1);
		host_model_i.rd(4'he, r);
		chk(r, 32'h0c);
		cyc(1);
		chk(irq, 1'b0);
		host_model_i.wr(4'hc, 8'h14, 4'h1);
		host_model_i.rd(4'hc, r);
		chk(r, 32'h14);
		chk(pin, 1'b0);
	endtask
	task automatic t_lock();
		host_model_i.wr(4'hd, 8'h20, 4'h1);
		@(posedge i_clock);
		win <= 1'b1;
		cyc(120);
		chk(pin, 1'b0);
		cyc(15);
		chk(pin, 1'b1);
		host_model_i.rd(4'hd, r);
		chk(r, 32'h23);
		host_model_i.wr(4'hd, 8'h18, 4'h1);
		miss();
		cyc(8);
		chk(pin, 1'b1);
		miss();
		cyc(5);
		chk(pin, 1'b0);
		cyc(20);
		chk(pin, 1'b0);
		cyc(16);
		chk(pin, 1'b1);
	endtask
	task automatic t_pin();
		logic [3:0] c;
		logic u;
		for (int k = 0; k < 16; k++) begin
			c = k[3:0];
			u = (c == 4'hb || c == 4'hc);
			if (c < 4'h5 && c != 4'h0)
				continue;
			host_model_i.wr(4'hd, {c, 4'h0}, 4'h1);
			@(posedge i_clock);
			src <= u ? 16'hffff : (16'h1 << c);
			cyc(4);
			chk(pin, !u);
			@(posedge i_clock);
			src <= 16'h0;
			cyc(4);
			chk(pin, 1'b0);
		end
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge i_clock);
		i_reset <= 1'b0;
		t_reset();
		t_power();
		t_synth();
		t_break();
		t_alarm();
		t_lock();
		t_pin();
		close_out();
	end
endmodule
